// ---- gsc_map.svh ----
// constants for the gauge switching control block
`ifndef GSC_MAP_SVH
`define GSC_MAP_SVH

// pressure code: unsigned, 1 lsb = 1.0E-9 of the current unit
`define GSC_PW          32
`define GSC_NCH         4
`define GSC_CHW         2
`define GSC_THR_ON_DEF  32'h004C_4B40
`define GSC_THR_OFF_DEF 32'h005B_8D80

`endif

// ---- gsc_pkg.sv ----
// types for the gauge switching control block
`include "gsc_map.svh"

package gsc_pkg;

  typedef struct packed {
    logic                 vld;
    logic [`GSC_PW-1:0]   val;
  } gsc_smp_s;

  typedef enum logic [3:0] {
    GSC_ON_MANUAL   = 4'h0,
    GSC_ON_HOT      = 4'h1,
    GSC_ON_CH_A1    = 4'h2,
    GSC_ON_CH_A2    = 4'h3,
    GSC_ON_CH_B1    = 4'h4,
    GSC_ON_CH_B2    = 4'h5,
    GSC_ON_HOT_A1   = 4'h6,
    GSC_ON_HOT_A2   = 4'h7,
    GSC_ON_HOT_B1   = 4'h8,
    GSC_ON_HOT_B2   = 4'h9,
    GSC_ON_PREV     = 4'hA,
    GSC_ON_PREV_A1  = 4'hB,
    GSC_ON_PREV_A2  = 4'hC,
    GSC_ON_PREV_B1  = 4'hD,
    GSC_ON_PREV_B2  = 4'hE
  } gsc_on_src_e;

  typedef enum logic [2:0] {
    GSC_OFF_MANUAL  = 3'h0,
    GSC_OFF_SELF    = 3'h1,
    GSC_OFF_CH_A1   = 3'h2,
    GSC_OFF_CH_A2   = 3'h3,
    GSC_OFF_CH_B1   = 3'h4,
    GSC_OFF_CH_B2   = 3'h5
  } gsc_off_src_e;

  typedef enum logic [1:0] {
    GSC_ST_INIT = 2'b01,
    GSC_ST_RUN  = 2'b10
  } gsc_state_e;

endpackage

// ---- gsc_chan_cmp.sv ----
// threshold comparison on one selected measurement channel
`timescale 1ns/1ps

module gsc_chan_cmp
  import gsc_pkg::*;
#(
  parameter bit P_ABOVE = 1'b0
) (
  input  wire logic                  i_clk,                 // system clock
  input  wire logic                  i_rst,                 // sync reset, high
  input  wire gsc_smp_s              i_smp [`GSC_NCH],      // channel samples
  input  wire logic [`GSC_CHW-1:0]   i_sel,                 // selected channel
  input  wire logic                  i_en,                  // comparison enabled
  input  wire logic [`GSC_PW-1:0]    i_thr,                 // threshold
  output logic                       o_hit                  // one-cycle hit pulse
);

  logic hit_r;
  logic hit_nxt;

  // ==========================================================
  // compare on each new sample only
  always_comb begin
    hit_nxt = 1'b0;
    if (i_en && i_smp[i_sel].vld) begin
      if (P_ABOVE) begin
        hit_nxt = (i_smp[i_sel].val > i_thr);
      end else begin
        hit_nxt = (i_smp[i_sel].val < i_thr);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= hit_nxt;
    end
  end

  assign o_hit = hit_r;

endmodule

// ---- gsc_gauge_ctrl.sv ----
// gauge switch-on / switch-off controller for one measuring channel
// Functional notes
// - manual on source: only the activation key switches the gauge on
// - hot start source: gauge switched on at every power-up
// - single channel source: switch on by that channel's pressure
// - hot start plus channel: on at power-up, then channel governs switch-on
// - previous source: restore pre-power state; activation key also switches on
// - previous plus channel: restore state, then channel governs switch-on
// - on threshold offered only for the four single-channel on sources
// - controlling pressure below on threshold switches on; default 5.0E-3
// - off threshold must be >= on threshold; bad settings rejected
// - manual off source: only the deactivation key switches the gauge off
// - self source: gauge off when its own pressure exceeds off threshold
// - channel off source: switch off by that channel's pressure
// - off threshold offered for self, channel, or hot start plus channel
// - controlling pressure above off threshold switches off; default 6.0E-3
// - channel sources usable only for fitted channels
// - gauge never switches itself on; hot start never switches off
// - switched-off conductivity gauge keeps measuring, shows off, board mate off
`timescale 1ns/1ps

module gsc_gauge_ctrl
  import gsc_pkg::*;
(
  input  wire logic                  i_clk,          // system clock, 100 MHz
  input  wire logic                  i_rst,          // sync reset = power-up, high
  input  wire gsc_on_src_e           i_on_src,       // activation source
  input  wire gsc_off_src_e          i_off_src,      // deactivation source
  input  wire logic                  i_key_on,       // activation key pulse
  input  wire logic                  i_key_off,      // deactivation key pulse
  input  wire gsc_smp_s              i_smp [`GSC_NCH], // pressure samples
  input  wire logic [`GSC_NCH-1:0]   i_fitted,       // channel fitted mask
  input  wire logic [`GSC_CHW-1:0]   i_own_ch,       // this gauge's channel
  input  wire logic                  i_is_tc,        // thermal-conductivity gauge
  input  wire logic                  i_prev_on,      // retained pre-power state
  input  wire logic                  i_thr_wr,       // threshold write strobe
  input  wire logic [`GSC_PW-1:0]    i_thr_on,       // new on threshold
  input  wire logic [`GSC_PW-1:0]    i_thr_off,      // new off threshold
  output logic                       o_gauge_on,     // gauge activated
  output logic                       o_meas_act,     // measuring circuit running
  output logic                       o_show_off,     // display off mark
  output logic                       o_mate_off,     // switch off board-mate cold cathode
  output logic [`GSC_PW-1:0]         o_thr_on,       // active on threshold
  output logic [`GSC_PW-1:0]         o_thr_off,      // active off threshold
  output logic                       o_thr_rej,      // threshold write rejected pulse
  output logic                       o_on_thr_vis,   // on threshold offered
  output logic                       o_off_thr_vis,  // off threshold offered
  output logic                       o_src_bad       // source names unfitted channel
);

  // ==========================================================
  // source decoding
  function automatic logic on_is_ch(input gsc_on_src_e s);
    on_is_ch = (s >= GSC_ON_CH_A1 && s <= GSC_ON_CH_B2) ||
               (s >= GSC_ON_HOT_A1 && s <= GSC_ON_HOT_B2) ||
               (s >= GSC_ON_PREV_A1);
  endfunction

  function automatic logic [`GSC_CHW-1:0] on_ch(input gsc_on_src_e s);
    logic [3:0] base;
    base = 4'h0;
    if (s >= GSC_ON_PREV_A1) begin
      base = 4'(s - GSC_ON_PREV_A1);
    end else if (s >= GSC_ON_HOT_A1) begin
      base = 4'(s - GSC_ON_HOT_A1);
    end else if (s >= GSC_ON_CH_A1) begin
      base = 4'(s - GSC_ON_CH_A1);
    end
    on_ch = base[`GSC_CHW-1:0];
  endfunction

  logic                  off_is_ch;
  logic [`GSC_CHW-1:0]   off_sel;
  logic                  on_sel_ok;
  logic                  off_sel_ok;
  logic                  on_cmp_en;
  logic                  off_cmp_en;
  logic                  on_hit;
  logic                  off_hit;
  logic [2:0]            off_idx;
  logic [`GSC_PW-1:0]    thr_on_r;
  logic [`GSC_PW-1:0]    thr_off_r;

  always_comb begin
    off_idx    = 3'(i_off_src - GSC_OFF_CH_A1);
    off_is_ch  = (i_off_src >= GSC_OFF_CH_A1);
    off_sel    = off_is_ch ? off_idx[`GSC_CHW-1:0] : i_own_ch;
    on_sel_ok  = i_fitted[on_ch(i_on_src)];
    off_sel_ok = i_fitted[off_sel];
    on_cmp_en  = on_is_ch(i_on_src) && on_sel_ok;
    off_cmp_en = (i_off_src != GSC_OFF_MANUAL) && off_sel_ok;
  end

  // ==========================================================
  // channel comparators
  gsc_chan_cmp #(.P_ABOVE(1'b0)) u_on_cmp (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_smp (i_smp),
    .i_sel (on_ch(i_on_src)),
    .i_en  (on_cmp_en),
    .i_thr (thr_on_r),
    .o_hit (on_hit)
  );

  gsc_chan_cmp #(.P_ABOVE(1'b1)) u_off_cmp (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_smp (i_smp),
    .i_sel (off_sel),
    .i_en  (off_cmp_en),
    .i_thr (thr_off_r),
    .o_hit (off_hit)
  );

  // ==========================================================
  // thresholds
  logic [`GSC_PW-1:0] thr_on_nxt;
  logic [`GSC_PW-1:0] thr_off_nxt;
  logic               rej_r;
  logic               rej_nxt;

  always_comb begin
    thr_on_nxt  = thr_on_r;
    thr_off_nxt = thr_off_r;
    rej_nxt     = 1'b0;
    if (i_thr_wr) begin
      if (i_thr_off >= i_thr_on) begin
        thr_on_nxt  = i_thr_on;
        thr_off_nxt = i_thr_off;
      end else begin
        rej_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      thr_on_r  <= `GSC_THR_ON_DEF;
      thr_off_r <= `GSC_THR_OFF_DEF;
      rej_r     <= 1'b0;
    end else begin
      thr_on_r  <= thr_on_nxt;
      thr_off_r <= thr_off_nxt;
      rej_r     <= rej_nxt;
    end
  end

  // ==========================================================
  // gauge state
  gsc_state_e st_r;
  gsc_state_e st_nxt;
  logic       on_r;
  logic       on_nxt;
  logic       key_on_ok;
  logic       key_off_ok;
  logic       on_ev;
  logic       off_ev;
  logic       on_vis_nxt;
  logic       off_vis_nxt;
  logic       bad_nxt;
  logic       on_vis_r;
  logic       off_vis_r;
  logic       bad_r;

  always_comb begin
    key_on_ok  = (i_on_src == GSC_ON_MANUAL) || (i_on_src == GSC_ON_PREV);
    key_off_ok = (i_off_src == GSC_OFF_MANUAL);
    on_ev      = (i_key_on && key_on_ok) || on_hit;
    off_ev     = (i_key_off && key_off_ok) || off_hit;
    st_nxt     = st_r;
    on_nxt     = on_r;
    unique case (st_r)
      GSC_ST_INIT: begin
        st_nxt = GSC_ST_RUN;
        if (i_on_src == GSC_ON_HOT ||
            (i_on_src >= GSC_ON_HOT_A1 && i_on_src <= GSC_ON_HOT_B2)) begin
          on_nxt = 1'b1;
        end else if (i_on_src >= GSC_ON_PREV) begin
          on_nxt = i_prev_on;
        end else begin
          on_nxt = 1'b0;
        end
      end
      GSC_ST_RUN: begin
        if (off_ev) begin
          on_nxt = 1'b0;
        end else if (on_ev) begin
          on_nxt = 1'b1;
        end
      end
      default: begin
        st_nxt = GSC_ST_INIT;
        on_nxt = 1'b0;
      end
    endcase
    on_vis_nxt  = (i_on_src >= GSC_ON_CH_A1 && i_on_src <= GSC_ON_CH_B2);
    off_vis_nxt = (i_off_src != GSC_OFF_MANUAL) ||
                  (i_on_src >= GSC_ON_HOT_A1 && i_on_src <= GSC_ON_HOT_B2);
    bad_nxt     = (on_is_ch(i_on_src) && !on_sel_ok) ||
                  (off_is_ch && !off_sel_ok);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r      <= GSC_ST_INIT;
      on_r      <= 1'b0;
      on_vis_r  <= 1'b0;
      off_vis_r <= 1'b0;
      bad_r     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      on_r      <= on_nxt;
      on_vis_r  <= on_vis_nxt;
      off_vis_r <= off_vis_nxt;
      bad_r     <= bad_nxt;
    end
  end

  // ==========================================================
  // indication of a switched-off conductivity gauge
  logic meas_r;
  logic meas_nxt;
  logic show_off_r;
  logic show_off_nxt;
  logic mate_off_r;
  logic mate_off_nxt;

  always_comb begin
    meas_nxt     = on_nxt || i_is_tc;
    show_off_nxt = !on_nxt && i_is_tc;
    mate_off_nxt = !on_nxt && i_is_tc;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meas_r     <= 1'b0;
      show_off_r <= 1'b0;
      mate_off_r <= 1'b0;
    end else begin
      meas_r     <= meas_nxt;
      show_off_r <= show_off_nxt;
      mate_off_r <= mate_off_nxt;
    end
  end

  assign o_gauge_on    = on_r;
  assign o_meas_act    = meas_r;
  assign o_show_off    = show_off_r;
  assign o_mate_off    = mate_off_r;
  assign o_thr_on      = thr_on_r;
  assign o_thr_off     = thr_off_r;
  assign o_thr_rej     = rej_r;
  assign o_on_thr_vis  = on_vis_r;
  assign o_off_thr_vis = off_vis_r;
  assign o_src_bad     = bad_r;

endmodule

// ---- gsc_chan_model.sv ----
// pressure channel model feeding one-cycle sample pulses
`timescale 1ns/1ps

module gsc_chan_model
  import gsc_pkg::*;
(
  input  wire logic               i_clk,          // clock
  input  wire logic [`GSC_NCH-1:0] i_fire,         // sample request per channel
  input  wire logic [`GSC_PW-1:0] i_val,          // pressure to report
  output gsc_smp_s                o_smp [`GSC_NCH] // samples to the block
);
  gsc_smp_s smp_r   [`GSC_NCH];
  gsc_smp_s smp_nxt [`GSC_NCH];

  always_comb begin
    for (int c = 0; c < `GSC_NCH; c++) begin
      smp_nxt[c].vld = i_fire[c];
      // stale data flips so it never passes for a fresh reading
      smp_nxt[c].val = i_fire[c] ? i_val : ~smp_r[c].val;
    end
  end

  always_ff @(posedge i_clk) smp_r <= smp_nxt;

  assign o_smp = smp_r;
endmodule

// ---- gsc_gauge_chk.sv ----
// concurrent checks on the gauge switching control ports
`timescale 1ns/1ps

module gsc_gauge_chk
  import gsc_pkg::*;
(
  input wire logic               i_clk,            // clock
  input wire logic               i_rst,            // sync reset
  input wire gsc_on_src_e        i_on_src,         // on source
  input wire gsc_off_src_e       i_off_src,        // off source
  input wire logic               i_key_on,         // on key
  input wire logic               i_key_off,        // off key
  input wire gsc_smp_s           i_smp [`GSC_NCH], // samples
  input wire logic [`GSC_NCH-1:0] i_fitted,        // fitted mask
  input wire logic               i_is_tc,          // tc gauge
  input wire logic               i_prev_on,        // retained state
  input wire logic               i_thr_wr,         // threshold write
  input wire logic [`GSC_PW-1:0] i_thr_on,         // new on threshold
  input wire logic [`GSC_PW-1:0] i_thr_off,        // new off threshold
  input wire logic               o_gauge_on,       // gauge on
  input wire logic               o_meas_act,       // measuring
  input wire logic               o_show_off,       // off mark
  input wire logic               o_mate_off,       // mate off
  input wire logic [`GSC_PW-1:0] o_thr_on,         // on threshold
  input wire logic [`GSC_PW-1:0] o_thr_off,        // off threshold
  input wire logic               o_thr_rej         // write refused
);
  logic       run_r;
  logic       run_nxt;
  logic [1:0] on_ch;
  logic [1:0] off_ch;

  // ======
  // run flag and selected channels
  always_comb begin
    run_nxt = !i_rst;
    on_ch   = i_on_src[1:0] + 2'h2;
    off_ch  = i_off_src[1:0] + 2'h2;
  end
  always_ff @(posedge i_clk) run_r <= run_nxt;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_on_low;
    run_r && i_on_src inside {[GSC_ON_CH_A1:GSC_ON_CH_B2]} && i_off_src == GSC_OFF_MANUAL && !i_key_off
      && i_fitted[on_ch] && i_smp[on_ch].vld && i_smp[on_ch].val < o_thr_on;
  endsequence
  sequence s_off_high;
    run_r && i_off_src inside {[GSC_OFF_CH_A1:GSC_OFF_CH_B2]} && i_fitted[off_ch]
      && i_smp[off_ch].vld && i_smp[off_ch].val > o_thr_off;
  endsequence

  // ======
  // assertions
  a_meas_marks: assert property (
    !$past(i_rst) |-> o_meas_act == (o_gauge_on | $past(i_is_tc))
      && o_show_off == (!o_gauge_on && $past(i_is_tc)) && o_mate_off == o_show_off)
    else $error("measure or off marks wrong");
  a_key_on: assert property (
    run_r && i_key_on && !i_key_off && i_on_src == GSC_ON_MANUAL && i_off_src == GSC_OFF_MANUAL |=> o_gauge_on)
    else $error("on key ignored");
  a_key_off: assert property (
    run_r && i_key_off && i_off_src == GSC_OFF_MANUAL |=> !o_gauge_on)
    else $error("off key ignored");
  a_thr_reject: assert property (
    i_thr_wr && i_thr_off < i_thr_on |=> o_thr_rej && $stable(o_thr_on) && $stable(o_thr_off))
    else $error("bad threshold pair taken");
  a_on_sample: assert property (
    s_on_low ##1 !i_key_off |=> o_gauge_on)
    else $error("low pressure did not switch on");
  a_off_sample: assert property (
    s_off_high |=> ##1 !o_gauge_on)
    else $error("high pressure did not switch off");
  a_hot_start: assert property (
    $fell(i_rst) && i_on_src inside {GSC_ON_HOT, [GSC_ON_HOT_A1:GSC_ON_HOT_B2]} |=> o_gauge_on)
    else $error("hot start missing");
  a_prev_start: assert property (
    $fell(i_rst) && i_on_src inside {GSC_ON_PREV, [GSC_ON_PREV_A1:GSC_ON_PREV_B2]} |=> o_gauge_on == $past(i_prev_on))
    else $error("previous state not restored");
endmodule

bind gsc_gauge_ctrl gsc_gauge_chk u_chk (.*);

// ---- tb_top.sv ----
// self-checking bench for the gauge switching control block
`timescale 1ns/1ps

module tb_top;
  import gsc_pkg::*;
  logic                i_clk, i_rst, i_key_on, i_key_off, i_is_tc, i_prev_on, i_thr_wr;
  logic                o_gauge_on, o_meas_act, o_show_off, o_mate_off, o_thr_rej;
  logic                o_on_thr_vis, o_off_thr_vis, o_src_bad;
  logic [`GSC_NCH-1:0] i_fitted, fire;
  logic [`GSC_CHW-1:0] i_own_ch;
  logic [`GSC_PW-1:0]  i_thr_on, i_thr_off, o_thr_on, o_thr_off, sval;
  gsc_on_src_e         i_on_src;
  gsc_off_src_e        i_off_src;
  gsc_smp_s            i_smp [`GSC_NCH];
  int                  num_errors, checks_done, cyc;
  localparam logic [`GSC_PW-1:0] thr_lo = 32'h0000_0064;
  localparam logic [`GSC_PW-1:0] thr_hi = 32'h0000_00C8;

  gsc_gauge_ctrl DUT (.*);
  gsc_chan_model u_chan (.i_clk(i_clk), .i_fire(fire), .i_val(sval), .o_smp(i_smp));

  // ======
  // clock and hang guard
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 1000) begin
      num_errors++;
      end_sim();
    end
  end

  // ======
  // access tasks
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic key(input logic on);
    i_key_on  = on;
    i_key_off = !on;
    tick(1);
    i_key_on  = 1'b0;
    i_key_off = 1'b0;
    tick(1);
  endtask
  task automatic sample(input int ch, input logic [`GSC_PW-1:0] val);
    fire = 4'h1 << ch;
    sval = val;
    tick(1);
    fire = 4'h0;
    tick(2);
  endtask
  task automatic wr(input logic [`GSC_PW-1:0] on, input logic [`GSC_PW-1:0] off);
    i_thr_wr  = 1'b1;
    i_thr_on  = on;
    i_thr_off = off;
    tick(1);
    i_thr_wr  = 1'b0;
  endtask
  task automatic rst_to(input gsc_on_src_e src);
    i_on_src = src;
    i_rst    = 1'b1;
    tick(2);
    i_rst    = 1'b0;
    tick(2);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ======
  // scenarios
  initial begin
    {i_key_on, i_key_off, i_prev_on, i_thr_wr, i_thr_on, i_thr_off, fire, sval} = '0;
    i_is_tc   = 1'b1;
    i_fitted  = 4'hF;
    i_own_ch  = 2'h3;
    i_off_src = GSC_OFF_MANUAL;
    rst_to(GSC_ON_MANUAL);
    chk({o_thr_on, o_thr_off}, {`GSC_THR_ON_DEF, `GSC_THR_OFF_DEF});
    key(1'b1);
    chk(o_gauge_on, 1'b1);
    key(1'b0);
    chk({o_gauge_on, o_meas_act, o_show_off, o_mate_off}, 4'h7);
    wr(thr_lo, thr_lo - 1);
    chk({o_thr_rej, o_thr_on}, {1'b1, `GSC_THR_ON_DEF});
    tick(1);
    wr(thr_hi, thr_hi);
    chk({o_thr_rej, o_thr_off}, {1'b0, thr_hi});
    tick(1);
    wr(thr_lo, thr_hi);
    i_on_src  = GSC_ON_CH_A2;
    i_off_src = GSC_OFF_CH_B1;
    tick(1);
    chk({o_on_thr_vis, o_off_thr_vis}, 2'h3);
    key(1'b1);
    sample(1, thr_lo);
    sample(2, 32'h0000_0000);
    chk(o_gauge_on, 1'b0);
    sample(1, thr_lo - 1);
    chk(o_gauge_on, 1'b1);
    sample(1, thr_hi + 1);
    sample(2, thr_hi);
    chk(o_gauge_on, 1'b1);
    sample(2, thr_hi + 1);
    chk(o_gauge_on, 1'b0);
    i_on_src  = GSC_ON_MANUAL;
    i_off_src = GSC_OFF_SELF;
    key(1'b1);
    sample(3, thr_hi + 1);
    chk(o_gauge_on, 1'b0);
    sample(3, 32'h0000_0000);
    chk(o_gauge_on, 1'b0);
    i_fitted  = 4'hD;
    i_on_src  = GSC_ON_CH_A2;
    i_off_src = GSC_OFF_MANUAL;
    tick(1);
    sample(1, 32'h0000_0000);
    chk({o_src_bad, o_gauge_on}, 2'h2);
    i_fitted = 4'hF;
    sample(1, 32'h0000_0000);
    tick(1);
    chk({o_src_bad, o_gauge_on}, 2'h1);
    rst_to(GSC_ON_HOT);
    chk(o_gauge_on, 1'b1);
    rst_to(GSC_ON_HOT_B2);
    chk({o_gauge_on, o_on_thr_vis, o_off_thr_vis}, 3'h5);
    key(1'b0);
    sample(3, 32'h0000_0000);
    chk(o_gauge_on, 1'b1);
    i_prev_on = 1'b1;
    rst_to(GSC_ON_PREV);
    chk(o_gauge_on, 1'b1);
    key(1'b0);
    key(1'b1);
    chk(o_gauge_on, 1'b1);
    i_prev_on = 1'b0;
    rst_to(GSC_ON_PREV_A1);
    chk(o_gauge_on, 1'b0);
    sample(0, 32'h0000_0000);
    chk(o_gauge_on, 1'b1);
    i_is_tc = 1'b0;
    tick(1);
    chk({o_gauge_on, o_meas_act, o_show_off, o_mate_off}, 4'hC);
    key(1'b0);
    chk({o_gauge_on, o_meas_act, o_show_off, o_mate_off}, 4'h0);
    end_sim();
  end
endmodule
